// File: include/orh_defines.svh
// Offsets, header field positions and limits for the region fetch and colour stage
`ifndef ORH_DEFINES_SVH
`define ORH_DEFINES_SVH
// Register map (byte addresses)
`define ORH_REG_CTRL      8'h00
`define ORH_REG_LIST      8'h04
`define ORH_REG_STATUS    8'h08
`define ORH_REG_REGIONS   8'h0c
`define ORH_CTRL_START    0
`define ORH_CTRL_FIELD    1
// Descriptor word indices
`define ORH_HDR_WORDS     4'ha
`define ORH_HDR_LAST      4'h9
`define ORH_W_MODE        4'h0
`define ORH_W_COLOUR      4'h1
`define ORH_W_TOTAL       4'h2
`define ORH_W_PITCH       4'h3
`define ORH_W_LEFT        4'h4
`define ORH_W_POS         4'h5
`define ORH_W_BOTTOM      4'h6
`define ORH_W_TOP         4'h7
`define ORH_W_PALETTE     4'h8
`define ORH_W_NEXT        4'h9
// Field positions inside the descriptor words
`define ORH_F_PPL         11:0
`define ORH_F_GAIN        17:12
`define ORH_F_GAIN_EN     18
`define ORH_F_BLEND       20:19
`define ORH_F_FILTER      22:21
`define ORH_F_LIST_END    23
`define ORH_F_FRESH       24
`define ORH_F_OFFSET      9:0
`define ORH_F_LOAD_START  17:10
`define ORH_F_LOAD_COUNT  25:18
`define ORH_F_WEIGHT      7:0
`define ORH_F_TOTAL       29:8
`define ORH_F_PITCH       12:0
`define ORH_F_Y_BOTTOM    23:13
`define ORH_F_X_LEFT      11:0
`define ORH_F_X_RIGHT     11:0
`define ORH_F_Y_TOP       22:12
`define ORH_F_SCALE       31:23
// Colour word byte lanes: red, green, blue, alpha from the top down
`define ORH_C_RED         31:24
`define ORH_C_GREEN       23:16
`define ORH_C_BLUE        15:8
`define ORH_C_ALPHA       7:0
// Limits
`define ORH_ALPHA_MAX     8'h80
`define ORH_COMP_MAX      10'h3ff
`define ORH_GAIN_SHIFT    5
`define ORH_WORD_STEP     32'h0000_0004
`endif

// File: include/orh_pkg.sv
// Types shared by the region fetch and colour stage
package orh_pkg;
   typedef enum logic [2:0] {
      ORH_IDLE = 3'h0,
      ORH_HDR  = 3'h1,
      ORH_PAL  = 3'h3,
      ORH_PIX  = 3'h2,
      ORH_NEXT = 3'h6
   } orh_state_type;
   typedef enum logic [1:0] {
      ORH_MIX_PIXEL  = 2'h0,
      ORH_MIX_GLOBAL = 2'h1,
      ORH_MIX_PROP   = 2'h2,
      ORH_MIX_NONE   = 2'h3
   } orh_blend_type;
endpackage

// File: rtl/orh_gain_stage.sv
// Per-region gain and offset applied to the three colour components
`timescale 1ns/1ps
`include "orh_defines.svh"
module orh_gain_stage #(
   parameter int COMP_W = 10,
   parameter int GAIN_W = 6
) (
   input  wire logic              clock,
   input  wire logic              reset,
   input  wire logic              gain_apply_flag,
   input  wire logic [GAIN_W-1:0] gain,
   input  wire logic [COMP_W-1:0] offset,
   input  wire logic [3*COMP_W-1:0] colour_in,
   output logic      [3*COMP_W-1:0] colour_out
);
   localparam int PROD_W = COMP_W + GAIN_W;

   // One lane per colour; alpha never enters this module
   for (genvar c = 0; c < 3; c++) begin : g_lane
      logic [PROD_W-1:0] prod;
      logic [PROD_W:0]   sum;
      assign prod = colour_in[c*COMP_W +: COMP_W] * gain;
      assign sum  = {1'b0, prod >> `ORH_GAIN_SHIFT} + {{(GAIN_W+1){1'b0}}, offset};
      always_ff @(posedge clock) begin
         if (reset) begin
            colour_out[c*COMP_W +: COMP_W] <= '0;
         end else if (!gain_apply_flag) begin
            colour_out[c*COMP_W +: COMP_W] <= colour_in[c*COMP_W +: COMP_W];
         end else if (sum > {{(GAIN_W+1){1'b0}}, `ORH_COMP_MAX}) begin
            colour_out[c*COMP_W +: COMP_W] <= `ORH_COMP_MAX;
         end else begin
            colour_out[c*COMP_W +: COMP_W] <= sum[COMP_W-1:0];
         end
      end
   end

   // Bypass passes the component untouched
   a_gain_bypass : assert property (@(posedge clock) disable iff (reset)
      !gain_apply_flag |=> colour_out == $past(colour_in))
      else $error("gain bypass altered colour");

   // Enabled lane zero equals saturated gain times input over 32 plus offset
   a_gain_math : assert property (@(posedge clock) disable iff (reset)
      gain_apply_flag |=> colour_out[COMP_W-1:0] ==
         ((($past(colour_in[COMP_W-1:0]) * $past(gain)) / 32 + $past(offset)) > 1023 ? 10'h3ff :
          10'(($past(colour_in[COMP_W-1:0]) * $past(gain)) / 32 + $past(offset))))
      else $error("gain result wrong");
endmodule

// File: rtl/orh_region_fetch.sv
// Region descriptor walker, palette loader, bitmap fetch and colour output
`timescale 1ns/1ps
`include "orh_defines.svh"
module orh_region_fetch #(
   parameter int LUT_DEPTH = 256
) (
   input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   output logic      [31:0] reg_rdata,
   output logic             mem_req,
   output logic      [31:0] mem_addr,
   input  wire logic        mem_ack,
   input  wire logic [31:0] mem_rdata,
   output logic             pix_valid,
   output logic      [9:0]  pix_red,
   output logic      [9:0]  pix_green,
   output logic      [9:0]  pix_blue,
   output logic      [7:0]  pix_alpha,
   output logic      [1:0]  flicker_filter_select,
   output logic             pix_top_line,
   output logic             pix_bottom_line,
   output logic             overlay_on
);
   orh_pkg::orh_state_type state_q;
   logic [31:0] hdr_q [0:9];
   logic [31:0] colour_lookup_table [0:LUT_DEPTH-1];
   logic [3:0]  word_idx_q;
   logic [31:0] list_ptr_q, desc_ptr_q, line_base_q, pix_addr_q, word_q;
   logic        start_q, field_sel_q, word_ok_q, line_first_q, overlay_q, req_q;
   logic [31:0] addr_q;
   logic [7:0]  load_ptr_q;
   logic [8:0]  load_left_q, load_done_q;
   logic [11:0] line_pix_q;
   logic [21:0] pix_left_q;
   logic [15:0] regions_q;
   logic [31:0] rdata_q;

   // Descriptor fields, decoded from the stored words
   logic [11:0] pixels_per_line;
   logic [12:0] pitch;
   logic [21:0] field_pixel_total;
   logic [7:0]  region_blend_weight, table_load_start, palette_load_count;
   logic [8:0]  alpha_scale_factor;
   logic        list_end_flag, fresh_palette_flag, gain_apply_flag;
   logic [1:0]  blend_select;
   logic [10:0] y_top, y_bottom;
   logic [11:0] x_left, x_right;
   assign pixels_per_line     = hdr_q[`ORH_W_MODE][`ORH_F_PPL];
   assign gain_apply_flag     = hdr_q[`ORH_W_MODE][`ORH_F_GAIN_EN];
   assign blend_select        = hdr_q[`ORH_W_MODE][`ORH_F_BLEND];
   assign list_end_flag       = hdr_q[`ORH_W_MODE][`ORH_F_LIST_END];
   assign fresh_palette_flag  = hdr_q[`ORH_W_MODE][`ORH_F_FRESH];
   assign table_load_start    = hdr_q[`ORH_W_COLOUR][`ORH_F_LOAD_START];
   assign palette_load_count  = hdr_q[`ORH_W_COLOUR][`ORH_F_LOAD_COUNT];
   assign region_blend_weight = hdr_q[`ORH_W_TOTAL][`ORH_F_WEIGHT];
   assign field_pixel_total   = hdr_q[`ORH_W_TOTAL][`ORH_F_TOTAL];
   assign pitch               = hdr_q[`ORH_W_PITCH][`ORH_F_PITCH];
   assign y_bottom            = hdr_q[`ORH_W_PITCH][`ORH_F_Y_BOTTOM];
   assign x_left              = hdr_q[`ORH_W_LEFT][`ORH_F_X_LEFT];
   assign x_right             = hdr_q[`ORH_W_POS][`ORH_F_X_RIGHT];
   assign y_top               = hdr_q[`ORH_W_POS][`ORH_F_Y_TOP];
   assign alpha_scale_factor  = hdr_q[`ORH_W_POS][`ORH_F_SCALE];

   // Pixels left in the current line decide the bottom-line mark
   logic [21:0] line_rest;
   logic        line_end;
   assign line_rest = {10'h000, pixels_per_line - line_pix_q};
   assign line_end  = (line_pix_q + 12'h001) == pixels_per_line;

   // Register bus: writes land at once, read data one cycle later
   always_ff @(posedge clock) begin
      if (reset) begin
         start_q     <= 1'b0;
         field_sel_q <= 1'b0;
         list_ptr_q  <= '0;
         rdata_q     <= '0;
      end else begin
         start_q <= reg_write && reg_addr == `ORH_REG_CTRL && reg_wdata[`ORH_CTRL_START];
         if (reg_write && reg_addr == `ORH_REG_CTRL) begin
            field_sel_q <= reg_wdata[`ORH_CTRL_FIELD];
         end
         if (reg_write && reg_addr == `ORH_REG_LIST) begin
            list_ptr_q <= reg_wdata;
         end
         if (reg_read) begin
            case (reg_addr)
               `ORH_REG_CTRL:    rdata_q <= {30'h0, field_sel_q, 1'b0};
               `ORH_REG_LIST:    rdata_q <= list_ptr_q;
               `ORH_REG_STATUS:  rdata_q <= {27'h0, overlay_q, state_q != orh_pkg::ORH_IDLE, state_q};
               `ORH_REG_REGIONS: rdata_q <= {16'h0, regions_q};
               default:          rdata_q <= '0;                                  // Unmapped reads zero
            endcase
         end else begin
            rdata_q <= '0;
         end
      end
   end
   assign reg_rdata = rdata_q;

   // Descriptor walk, palette fetch and bitmap fetch share one memory port
   logic       emit;
   logic [7:0] emit_index;
   always_ff @(posedge clock) begin
      if (reset) begin
         state_q      <= orh_pkg::ORH_IDLE;
         req_q        <= 1'b0;
         addr_q       <= '0;
         word_idx_q   <= '0;
         desc_ptr_q   <= '0;
         load_ptr_q   <= '0;
         load_left_q  <= '0;
         line_base_q  <= '0;
         pix_addr_q   <= '0;
         word_q       <= '0;
         word_ok_q    <= 1'b0;
         line_pix_q   <= '0;
         line_first_q <= 1'b0;
         pix_left_q   <= '0;
         overlay_q    <= 1'b0;
         regions_q    <= '0;
         emit         <= 1'b0;
         emit_index   <= '0;
         for (int i = 0; i < 10; i++) begin
            hdr_q[i] <= '0;
         end
      end else begin
         emit <= 1'b0;
         if (mem_ack) begin
            req_q <= 1'b0;
         end
         case (state_q)
            orh_pkg::ORH_IDLE: begin
               if (start_q) begin
                  desc_ptr_q <= list_ptr_q;
                  word_idx_q <= '0;
                  overlay_q  <= 1'b1;
                  state_q    <= orh_pkg::ORH_HDR;
               end
            end
            orh_pkg::ORH_HDR: begin
               if (!req_q) begin
                  req_q  <= 1'b1;
                  addr_q <= desc_ptr_q + {26'h0, word_idx_q, 2'b00};
               end else if (mem_ack) begin
                  hdr_q[word_idx_q] <= mem_rdata;
                  word_idx_q        <= word_idx_q + 4'h1;
                  if (word_idx_q == `ORH_HDR_LAST) begin
                     load_ptr_q   <= hdr_q[`ORH_W_COLOUR][`ORH_F_LOAD_START];
                     load_left_q  <= {1'b0, hdr_q[`ORH_W_COLOUR][`ORH_F_LOAD_COUNT]} + 9'h001;
                     addr_q       <= hdr_q[`ORH_W_PALETTE];
                     line_base_q  <= field_sel_q ? hdr_q[`ORH_W_BOTTOM] : hdr_q[`ORH_W_TOP];
                     pix_addr_q   <= field_sel_q ? hdr_q[`ORH_W_BOTTOM] : hdr_q[`ORH_W_TOP];
                     pix_left_q   <= hdr_q[`ORH_W_TOTAL][`ORH_F_TOTAL];
                     line_pix_q   <= '0;
                     line_first_q <= 1'b1;
                     word_ok_q    <= 1'b0;
                     state_q      <= hdr_q[`ORH_W_MODE][`ORH_F_FRESH] ? orh_pkg::ORH_PAL
                                                                      : orh_pkg::ORH_PIX;
                  end
               end
            end
            orh_pkg::ORH_PAL: begin
               if (!req_q && !mem_ack) begin
                  req_q <= 1'b1;
               end else if (mem_ack) begin
                  load_ptr_q  <= load_ptr_q + 8'h01;                                // Wraps inside 256 entries
                  load_left_q <= load_left_q - 9'h001;
                  addr_q      <= addr_q + `ORH_WORD_STEP;
                  if (load_left_q == 9'h001) begin
                     state_q <= orh_pkg::ORH_PIX;
                  end
               end
            end
            orh_pkg::ORH_PIX: begin
               if (pix_left_q == '0 || pixels_per_line == '0) begin
                  state_q <= orh_pkg::ORH_NEXT;
               end else if (word_ok_q) begin
                  emit       <= 1'b1;
                  emit_index <= word_q[{pix_addr_q[1:0], 3'b000} +: 8];
                  pix_left_q <= pix_left_q - 22'h000001;
                  line_pix_q <= line_pix_q + 12'h001;
                  pix_addr_q <= pix_addr_q + 32'h0000_0001;
                  if (pix_addr_q[1:0] == 2'b11) begin
                     word_ok_q <= 1'b0;
                  end
                  if (line_end) begin
                     line_first_q <= 1'b0;
                     line_pix_q   <= '0;
                     line_base_q  <= line_base_q + {19'h0, pitch};
                     pix_addr_q   <= line_base_q + {19'h0, pitch};
                     word_ok_q    <= 1'b0;
                  end
               end else if (!req_q && !mem_ack) begin
                  req_q  <= 1'b1;
                  addr_q <= {pix_addr_q[31:2], 2'b00};
               end else if (mem_ack) begin
                  word_q    <= mem_rdata;
                  word_ok_q <= 1'b1;
               end
            end
            orh_pkg::ORH_NEXT: begin
               regions_q  <= regions_q + 16'h0001;
               desc_ptr_q <= hdr_q[`ORH_W_NEXT];
               word_idx_q <= '0;
               if (list_end_flag) begin
                  overlay_q <= 1'b0;
                  state_q   <= orh_pkg::ORH_IDLE;
               end else begin
                  state_q <= orh_pkg::ORH_HDR;
               end
            end
            default: state_q <= orh_pkg::ORH_IDLE;
         endcase
      end
   end
   assign mem_req  = req_q;
   assign mem_addr = addr_q;

   // Line marks travel with the pixel; the top mark drops once the first line has gone out
   logic s1_top, s1_bottom;
   always_ff @(posedge clock) begin
      if (reset) begin
         s1_top    <= 1'b0;
         s1_bottom <= 1'b0;
      end else begin
         s1_top    <= word_ok_q && line_first_q;
         s1_bottom <= word_ok_q && pix_left_q <= line_rest;
      end
   end

   // Palette table: only the load path writes, indexed by load pointer
   always_ff @(posedge clock) begin
      if (state_q == orh_pkg::ORH_PAL && mem_ack) begin
         colour_lookup_table[load_ptr_q] <= mem_rdata;
      end
   end

   // Stage two: the pixel index reads the table directly
   logic [31:0] entry_q;
   logic        s2_valid, s2_top, s2_bottom;
   always_ff @(posedge clock) begin
      if (reset) begin
         entry_q   <= '0;
         s2_valid  <= 1'b0;
         s2_top    <= 1'b0;
         s2_bottom <= 1'b0;
      end else begin
         entry_q   <= colour_lookup_table[emit_index];
         s2_valid  <= emit;
         s2_top    <= s1_top && emit;
         s2_bottom <= s1_bottom && emit;
      end
   end

   // Blend factor per mode; clamps keep it inside 0 to 128
   logic [7:0]  alpha_cl, weight_cl, factor;
   logic [15:0] prop_mul, prop_div;
   assign alpha_cl  = entry_q[`ORH_C_ALPHA] > `ORH_ALPHA_MAX ? `ORH_ALPHA_MAX : entry_q[`ORH_C_ALPHA];
   assign weight_cl = region_blend_weight > `ORH_ALPHA_MAX ? `ORH_ALPHA_MAX : region_blend_weight;
   assign prop_mul  = alpha_cl * alpha_scale_factor[7:0];
   assign prop_div  = alpha_scale_factor[7:0] == 8'h00 ? 16'h0080 :
                      16'(({8'h00, alpha_cl} << 7) / {8'h00, alpha_scale_factor[7:0]});
   always_comb begin
      case (orh_pkg::orh_blend_type'(blend_select))
         orh_pkg::ORH_MIX_PIXEL:  factor = alpha_cl;
         orh_pkg::ORH_MIX_GLOBAL: factor = weight_cl;
         orh_pkg::ORH_MIX_PROP: begin
            if (alpha_scale_factor[8]) begin
               factor = prop_mul > 16'h0080 ? `ORH_ALPHA_MAX : prop_mul[7:0];
            end else begin
               factor = prop_div > 16'h0080 ? `ORH_ALPHA_MAX : prop_div[7:0];
            end
         end
         default: factor = `ORH_ALPHA_MAX;                                          // No blend: opaque
      endcase
   end

   // Stage three: alpha and marks registered beside the gain lanes
   logic        s3_valid, s3_top, s3_bottom;
   logic [7:0]  s3_alpha;
   logic [1:0]  s3_filter;
   always_ff @(posedge clock) begin
      if (reset) begin
         s3_valid  <= 1'b0;
         s3_top    <= 1'b0;
         s3_bottom <= 1'b0;
         s3_alpha  <= '0;
         s3_filter <= '0;
      end else begin
         s3_valid  <= s2_valid;
         s3_top    <= s2_top;
         s3_bottom <= s2_bottom;
         s3_alpha  <= factor;
         s3_filter <= hdr_q[`ORH_W_MODE][`ORH_F_FILTER];
      end
   end

   // Eight-bit colours widened to ten by repeating the top bits
   logic [29:0] colour_wide, colour_gain;
   assign colour_wide = {entry_q[`ORH_C_RED],   entry_q[31:30],
                         entry_q[`ORH_C_GREEN], entry_q[23:22],
                         entry_q[`ORH_C_BLUE],  entry_q[15:14]};
   orh_gain_stage #(.COMP_W(10), .GAIN_W(6)) u_gain (
      .clock           (clock),
      .reset           (reset),
      .gain_apply_flag (gain_apply_flag),
      .gain            (hdr_q[`ORH_W_MODE][`ORH_F_GAIN]),
      .offset          (hdr_q[`ORH_W_COLOUR][`ORH_F_OFFSET]),
      .colour_in       (colour_wide),
      .colour_out      (colour_gain)
   );
   assign pix_valid             = s3_valid;
   assign pix_red               = colour_gain[29:20];
   assign pix_green             = colour_gain[19:10];
   assign pix_blue              = colour_gain[9:0];
   assign pix_alpha             = s3_alpha;
   assign flicker_filter_select = s3_filter;
   assign pix_top_line          = s3_top;
   assign pix_bottom_line       = s3_bottom;
   assign overlay_on            = overlay_q;

   // Count table writes per load to check the run length
   always_ff @(posedge clock) begin
      if (reset || state_q != orh_pkg::ORH_PAL) begin
         load_done_q <= '0;
      end else if (mem_ack) begin
         load_done_q <= load_done_q + 9'h001;
      end
   end

   a_palette_run_length : assert property (@(posedge clock) disable iff (reset)
      state_q == orh_pkg::ORH_PAL && mem_ack && load_left_q == 9'h001
      |-> load_done_q == {1'b0, palette_load_count})
      else $error("palette run length wrong");

   a_alpha_clamp_range : assert property (@(posedge clock) disable iff (reset)
      pix_valid |-> pix_alpha <= 8'h80)
      else $error("alpha above full opaque");

   a_global_weight_use : assert property (@(posedge clock) disable iff (reset)
      s2_valid && blend_select == 2'h1 |=> pix_alpha ==
         ($past(region_blend_weight) > 8'h80 ? 8'h80 : $past(region_blend_weight)))
      else $error("global weight not applied");

   a_no_blend_opaque : assert property (@(posedge clock) disable iff (reset)
      s2_valid && blend_select == 2'h3 |=> pix_alpha == 8'h80)
      else $error("no-blend mode not opaque");

   a_list_end_off : assert property (@(posedge clock) disable iff (reset)
      state_q == orh_pkg::ORH_NEXT && list_end_flag |=> !overlay_on && state_q == orh_pkg::ORH_IDLE)
      else $error("overlay not switched off at list end");

   sequence s_header_done_keep;
      state_q == orh_pkg::ORH_HDR && mem_ack && word_idx_q == `ORH_HDR_LAST && !fresh_palette_flag;
   endsequence
   a_palette_kept : assert property (@(posedge clock) disable iff (reset)
      s_header_done_keep |=> state_q == orh_pkg::ORH_PIX)
      else $error("palette reloaded without fresh flag");

   a_lut_write_pos : assert property (@(posedge clock) disable iff (reset)
      state_q == orh_pkg::ORH_PAL && mem_ack
      |-> load_ptr_q == 8'(table_load_start + load_done_q[7:0]))
      else $error("table write position wrong");

   a_pixel_byte_order : assert property (@(posedge clock) disable iff (reset)
      state_q == orh_pkg::ORH_PIX && word_ok_q && pix_left_q != '0 && pixels_per_line != '0
      |=> emit && emit_index == $past(word_q[{pix_addr_q[1:0], 3'b000} +: 8]))
      else $error("pixel byte order wrong");
endmodule

// File: verification/orh_mem_model.sv
// Behavioural memory that answers the region fetch's word reads
`timescale 1ns/1ps
module orh_mem_model (
   input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic        mem_req,
   input  wire logic [31:0] mem_addr,
   output logic             mem_ack,
   output logic      [31:0] mem_rdata
);
   logic [31:0] mem [0:63];
   logic [1:0]  wait_q;
   logic        slow_q;
   // Alternate prompt and three-cycle answers; idle data toggles so stale words never look valid
   always_ff @(posedge clock) begin
      if (reset) begin
         mem_ack   <= 1'b0;
         mem_rdata <= 32'h0;
         wait_q    <= 2'h0;
         slow_q    <= 1'b0;
      end else if (mem_req && !mem_ack && wait_q == {slow_q, slow_q}) begin
         mem_ack   <= 1'b1;
         mem_rdata <= mem[mem_addr[7:2]];
         wait_q    <= 2'h0;
         slow_q    <= !slow_q;
      end else begin
         mem_ack   <= 1'b0;
         mem_rdata <= ~mem_rdata;
         wait_q    <= wait_q + {1'b0, mem_req && !mem_ack};
      end
   end
endmodule

// File: verification/orh_region_fetch_test.sv
// Self-checking bench for the region fetch: two linked regions through the colour stage
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
   $display("unexpected %s exp %h got %h", n, e, g); end end
module orh_region_fetch_test;
   logic clock = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0, mem_req, mem_ack, pix_valid;
   logic [7:0] reg_addr = 8'h0, pix_alpha;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, mem_addr, mem_rdata;
   logic [9:0] pix_red, pix_green, pix_blue;
   logic [1:0] flicker_filter_select;
   logic pix_top_line, pix_bottom_line, overlay_on;
   int miscompares = 0, checks_done = 0;
   // Two headers, palette at 0x60, bitmaps at 0x80/0x84 (word aligned, shared blocks)
   localparam logic [31:0] IMG [34] = '{32'h01260004, 32'h00040810, 32'h400, 32'h4, 0, 0, 32'h80, 32'h80,
      32'h60, 32'h28, 32'h00dbf004, 32'h03fc0010, 32'h400, 32'h4, 0, 0, 32'h84, 32'h84, 32'h60, 0,
      0, 0, 0, 0, 32'h804000ff, 32'hffff0120, 0, 0, 0, 0, 0, 0, 32'h02030302, 32'h03020203};
   // Expected {filter, top, bottom, red, green, blue, alpha} per pixel: first walk, then second walk
   localparam logic [41:0] EXP [16] = '{
      {4'h7, 10'h212, 10'h111, 10'h010, 8'h80}, {4'h7, 10'h3ff, 10'h3ff, 10'h014, 8'h20},
      {4'h7, 10'h3ff, 10'h3ff, 10'h014, 8'h20}, {4'h7, 10'h212, 10'h111, 10'h010, 8'h80},
      {4'hb, 10'h3ff, 10'h3ff, 10'h004, 8'h80}, {4'hb, 10'h202, 10'h101, 10'h000, 8'h80},
      {4'hb, 10'h202, 10'h101, 10'h000, 8'h80}, {4'hb, 10'h3ff, 10'h3ff, 10'h004, 8'h80},
      {4'h6, 10'h212, 10'h111, 10'h010, 8'h30}, {4'h6, 10'h3ff, 10'h3ff, 10'h014, 8'h30},
      {4'h5, 10'h3ff, 10'h3ff, 10'h014, 8'h30}, {4'h5, 10'h212, 10'h111, 10'h010, 8'h30},
      {4'hb, 10'h202, 10'h101, 10'h000, 8'h80}, {4'hb, 10'h3ff, 10'h3ff, 10'h004, 8'h40},
      {4'hb, 10'h3ff, 10'h3ff, 10'h004, 8'h40}, {4'hb, 10'h202, 10'h101, 10'h000, 8'h80}};
   orh_region_fetch orh_region_fetch_inst (.clock(clock), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
      .pix_valid(pix_valid), .pix_red(pix_red), .pix_green(pix_green), .pix_blue(pix_blue),
      .pix_alpha(pix_alpha), .flicker_filter_select(flicker_filter_select),
      .pix_top_line(pix_top_line), .pix_bottom_line(pix_bottom_line), .overlay_on(overlay_on));
   orh_mem_model orh_mem_model_inst (.clock(clock), .reset(reset), .mem_req(mem_req),
      .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   // Free-running 40 MHz clock
   always #12.5 clock = !clock;
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // Catch eight pixel pulses in output order, compare each whole, then wait for the list to end
   task automatic expect_walk(input int first, input logic [15:0] regions);
      logic [31:0] d;
      logic [41:0] got;
      int w;
      for (int p = first; p < first + 8; p++) begin
         w = 0;
         do begin @(posedge clock); #1 w++; end while (pix_valid !== 1'b1 && w < 500);
         `CHK("pixel valid", 1'b1, pix_valid)
         got = {flicker_filter_select, pix_top_line, pix_bottom_line, pix_red, pix_green, pix_blue, pix_alpha};
         `CHK("pixel", EXP[p], got)
      end
      w = 0;
      while (overlay_on !== 1'b0 && w < 500) begin @(posedge clock); #1 w++; end
      `CHK("overlay", 1'b0, overlay_on)
      reg_rd(8'h0c, d);
      `CHK("regions", regions, d[15:0])
   endtask
   // Walk both regions from the top field pointer
   task automatic run_two_regions;
      logic [31:0] d;
      for (int i = 0; i < 34; i++) orh_mem_model_inst.mem[i] = IMG[i];
      reg_wr(8'h04, 32'h0);
      reg_wr(8'h00, 32'h1);
      expect_walk(0, 16'h0002);
      reg_rd(8'h10, d);
      `CHK("unmapped", 32'h0, d)
      $display("test run_two_regions done");
   endtask
   // Second walk: bottom field, global and proportional blends, first region two lines deep
   task automatic run_blend_modes;
      logic [31:0] d;
      orh_mem_model_inst.mem[0]  = 32'h012e0002; // Global blend, two pixels a line
      orh_mem_model_inst.mem[2]  = 32'h00000430; // Weight 30h, four pixels
      orh_mem_model_inst.mem[10] = 32'h00d3f004; // Proportional blend, list end
      orh_mem_model_inst.mem[15] = 32'h81000000; // Multiply alpha by two
      orh_mem_model_inst.mem[16] = 32'h00000080; // Bottom pointer differs from top here
      reg_wr(8'h00, 32'h3);
      expect_walk(8, 16'h0004);
      reg_rd(8'h00, d);
      `CHK("control", 32'h2, d)
      reg_rd(8'h08, d);
      `CHK("status", 32'h0, d)
      $display("test run_blend_modes done");
   endtask
   task automatic report_and_stop;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Cut a hang short well beyond the expected run length
   initial begin
      repeat (20000) @(posedge clock);
      miscompares++;
      report_and_stop();
   end
   initial begin
      repeat (16) @(posedge clock);
      reset <= 1'b0;
      run_two_regions();
      run_blend_modes();
      report_and_stop();
   end
endmodule
